// [rtl/utmio_main.v]
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "utmio_defs.vh"
module utmio_main #(
	parameter [25:0] FRAME_CYC_10 = `UTMIO_FRAME_10_MS * `UTMIO_CYC_PER_MS,
	parameter [25:0] FRAME_CYC_20 = `UTMIO_FRAME_20_MS * `UTMIO_CYC_PER_MS,
	parameter [25:0] FRAME_CYC_40 = `UTMIO_FRAME_40_MS * `UTMIO_CYC_PER_MS,
	parameter [25:0] FRAME_CYC_80 = `UTMIO_FRAME_80_MS * `UTMIO_CYC_PER_MS,
	parameter [25:0] FRAME_CYC_2560 = `UTMIO_FRAME_2560_MS * `UTMIO_CYC_PER_MS
) (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// trigger and clock pins
	input wire frame_sync_trigger,
	input wire burst_gate_in,
	input wire tpc_user_trigger,
	input wire external_chip_clock_input,
	// routed outputs
	output reg event1_out,
	output reg event2_out,
	output reg event3_out,
	output reg event4_out,
	output reg data_out,
	output reg data_clock_out,
	output reg symbol_sync_out
);
	wire [3:0] pin_raw;
	wire [3:0] pin_lvl;
	reg [3:0] pin_prev;
	wire [3:0] pin_rise;
	reg [`UTMIO_CTRL_W-1:0] ctrl;
	reg [27:0] route;
	reg [15:0] tpc_file;
	wire clk_ext = ctrl[`UTMIO_CTRL_CLK_EXT];
	wire [1:0] clock_multiplier_select = ctrl[`UTMIO_CTRL_MULT_HI:`UTMIO_CTRL_MULT_LO];
	wire sync_source_select = ctrl[`UTMIO_CTRL_SYNC_SFN];
	wire [2:0] per_sel = ctrl[`UTMIO_CTRL_PER_HI:`UTMIO_CTRL_PER_LO];
	wire prach_mode = ctrl[`UTMIO_CTRL_PRACH];

	assign pin_raw = {external_chip_clock_input, tpc_user_trigger, burst_gate_in,
		frame_sync_trigger};
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin
			utmio_sync u_sync (
				.pclk(pclk),
				.presetn(presetn),
				.din(pin_raw[gi]),
				.dout(pin_lvl[gi])
			);
		end
	endgenerate
	assign pin_rise = pin_lvl & ~pin_prev;

	// internal chip clock: fractional accumulator, 3840 per 25000
	reg [14:0] acc;
	wire [15:0] acc_sum = {1'b0, acc} + 16'h0F00;
	wire int_tick = (acc_sum >= 16'h61A8);
	// external clock: period measurement and subdivision
	reg [7:0] ext_per;
	reg [7:0] ext_cnt;
	reg [7:0] sub_cnt;
	reg [1:0] ticks_left;
	reg ext_tick;
	wire [7:0] sub_step = (clock_multiplier_select == `UTMIO_MULT_X4) ? {2'h0, ext_per[7:2]} :
		(clock_multiplier_select == `UTMIO_MULT_X2) ? {1'h0, ext_per[7:1]} : ext_per;
	wire [1:0] extra_ticks = (clock_multiplier_select == `UTMIO_MULT_X4) ? 2'h3 :
		(clock_multiplier_select == `UTMIO_MULT_X2) ? 2'h1 : 2'h0;
	wire chip_tick = clk_ext ? ext_tick : int_tick;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_prev <= 4'h0;
			acc <= 15'h0000;
			ext_per <= 8'h00;
			ext_cnt <= 8'h00;
			sub_cnt <= 8'h00;
			ticks_left <= 2'h0;
			ext_tick <= 1'b0;
		end else begin
			pin_prev <= pin_lvl;
			acc <= int_tick ? acc_sum[14:0] - 15'h61A8 : acc_sum[14:0];
			ext_tick <= 1'b0;
			if (ext_cnt != 8'hFF) begin
				ext_cnt <= ext_cnt + 8'h01;
			end
			if (pin_rise[3]) begin
				// saturate so a long gap never measures as zero
				ext_per <= (ext_cnt == 8'hFF) ? 8'hFF : ext_cnt + 8'h01;
				ext_cnt <= 8'h00;
				ext_tick <= 1'b1;
				sub_cnt <= 8'h01;
				ticks_left <= extra_ticks;
			end else if (ticks_left != 2'h0) begin
				if (sub_cnt >= sub_step) begin
					ext_tick <= 1'b1;
					sub_cnt <= 8'h01;
					ticks_left <= ticks_left - 2'h1;
				end else begin
					sub_cnt <= sub_cnt + 8'h01;
				end
			end
		end
	end

	// frame timing
	reg [25:0] frame_per;
	reg [25:0] frame_cnt;
	reg [11:0] sfn;
	reg frame_pend;
	reg reply_pend;
	reg sfn0_pend;
	reg prach_pend;
	reg tpc_pend;
	always @* begin
		case (per_sel)
			`UTMIO_PER_10: frame_per = FRAME_CYC_10;
			`UTMIO_PER_20: frame_per = FRAME_CYC_20;
			`UTMIO_PER_40: frame_per = FRAME_CYC_40;
			`UTMIO_PER_80: frame_per = FRAME_CYC_80;
			`UTMIO_PER_2560: frame_per = FRAME_CYC_2560;
			default: frame_per = FRAME_CYC_10;
		endcase
	end
	wire frame_wrap = (frame_cnt >= frame_per - 26'h0000001);

	// chip-aligned sources
	reg reply_src;
	reg frame_src;
	reg sfn0_src;
	reg prach_active;
	reg [15:0] prach_cnt;
	reg tpc_src;
	reg tpc_bit;
	reg [3:0] tpc_ptr;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_cnt <= 26'h0000000;
			sfn <= 12'h000;
			frame_pend <= 1'b0;
			reply_pend <= 1'b0;
			sfn0_pend <= 1'b0;
			prach_pend <= 1'b0;
			tpc_pend <= 1'b0;
			reply_src <= 1'b0;
			frame_src <= 1'b0;
			sfn0_src <= 1'b0;
			prach_active <= 1'b0;
			prach_cnt <= 16'h0000;
			tpc_src <= 1'b0;
			tpc_bit <= 1'b0;
			tpc_ptr <= 4'h0;
		end else begin
			if (pin_rise[0]) begin
				frame_cnt <= 26'h0000000;
				if (sync_source_select) begin
					sfn <= 12'h000;
				end else begin
					sfn <= sfn + 12'h001;
				end
			end else if (frame_wrap) begin
				frame_cnt <= 26'h0000000;
				sfn <= sfn + 12'h001;
			end else begin
				frame_cnt <= frame_cnt + 26'h0000001;
			end
			// pending events: a new event wins over consumption
			frame_pend <= (pin_rise[0] & ~sync_source_select) | frame_wrap |
				(frame_pend & ~chip_tick);
			reply_pend <= pin_rise[0] | (reply_pend & ~chip_tick);
			sfn0_pend <= (pin_rise[0] & sync_source_select) | (sfn0_pend & ~chip_tick);
			prach_pend <= (pin_rise[1] & prach_mode) | (prach_pend & ~chip_tick);
			tpc_pend <= (pin_rise[2] & ~prach_mode) | (tpc_pend & ~chip_tick);
			if (chip_tick) begin
				reply_src <= reply_pend;
				frame_src <= frame_pend;
				sfn0_src <= sfn0_pend;
				tpc_src <= tpc_pend;
				if (prach_pend) begin
					prach_active <= 1'b1;
					prach_cnt <= `UTMIO_PRACH_CHIPS;
				end else if (prach_cnt != 16'h0000) begin
					prach_cnt <= prach_cnt - 16'h0001;
				end else begin
					prach_active <= 1'b0;
				end
				if (tpc_pend) begin
					tpc_bit <= tpc_file[tpc_ptr];
					tpc_ptr <= tpc_ptr + 4'h1;
				end
			end
		end
	end

	// output routing
	reg [6:0] next_out;
	reg [6:0] out_q;
	integer k;
	always @* begin
		for (k = 0; k < 7; k = k + 1) begin
			case (route[4*k +: 4])
				`UTMIO_SEL_CHIP: next_out[k] = chip_tick;
				`UTMIO_SEL_REPLY: next_out[k] = reply_src;
				`UTMIO_SEL_FRAME: next_out[k] = frame_src;
				`UTMIO_SEL_PRACH: next_out[k] = prach_active;
				`UTMIO_SEL_TPC: next_out[k] = tpc_src ? tpc_bit : 1'b0;
				`UTMIO_SEL_SFN0: next_out[k] = sfn0_src;
				default: next_out[k] = 1'b0;
			endcase
		end
	end
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_q <= 7'h00;
			event1_out <= 1'b0;
			event2_out <= 1'b0;
			event3_out <= 1'b0;
			event4_out <= 1'b0;
			data_out <= 1'b0;
			data_clock_out <= 1'b0;
			symbol_sync_out <= 1'b0;
		end else begin
			out_q <= next_out;
			event1_out <= next_out[0];
			event2_out <= next_out[1];
			event3_out <= next_out[2];
			event4_out <= next_out[3];
			data_out <= next_out[4];
			data_clock_out <= next_out[5];
			symbol_sync_out <= next_out[6];
		end
	end

	// apb: no wait state, pready in the first access cycle, registered answer
	wire acc_phase = psel & penable & pready;
	wire addr_ok = (paddr == `UTMIO_OFF_CTRL) | (paddr == `UTMIO_OFF_ROUTE) |
		(paddr == `UTMIO_OFF_TPC_FILE) | (paddr == `UTMIO_OFF_STATUS);
	reg [31:0] rd_mux;
	always @* begin
		case (paddr)
			`UTMIO_OFF_CTRL: rd_mux = {24'h000000, ctrl};
			`UTMIO_OFF_ROUTE: rd_mux = {4'h0, route};
			`UTMIO_OFF_TPC_FILE: rd_mux = {16'h0000, tpc_file};
			`UTMIO_OFF_STATUS: rd_mux = {sfn, out_q, prach_active, tpc_bit, tpc_ptr,
				1'b0, ext_per[5:0]};
			default: rd_mux = 32'h00000000;
		endcase
	end
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= `UTMIO_CTRL_RST;
			route <= `UTMIO_ROUTE_RST;
			tpc_file <= `UTMIO_TPC_FILE_RST;
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable & ~pready;
			pslverr <= psel & ~penable & ~pready & ~addr_ok;
			if (psel & ~penable & ~pready) begin
				prdata <= pwrite ? 32'h00000000 : rd_mux;
			end
			if (acc_phase & pwrite) begin
				case (paddr)
					`UTMIO_OFF_CTRL: ctrl <= pwdata[`UTMIO_CTRL_W-1:0];
					`UTMIO_OFF_ROUTE: route <= pwdata[27:0];
					`UTMIO_OFF_TPC_FILE: tpc_file <= pwdata[15:0];
					default: ;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// [rtl/utmio_defs.vh]
`ifndef UTMIO_DEFS_VH
`define UTMIO_DEFS_VH

// register byte offsets
`define UTMIO_OFF_CTRL 12'h000
`define UTMIO_OFF_ROUTE 12'h004
`define UTMIO_OFF_TPC_FILE 12'h008
`define UTMIO_OFF_STATUS 12'h00C

// control field positions
`define UTMIO_CTRL_CLK_EXT 0
`define UTMIO_CTRL_MULT_LO 1
`define UTMIO_CTRL_MULT_HI 2
`define UTMIO_CTRL_SYNC_SFN 3
`define UTMIO_CTRL_PER_LO 4
`define UTMIO_CTRL_PER_HI 6
`define UTMIO_CTRL_PRACH 7
`define UTMIO_CTRL_W 8

// reset values
`define UTMIO_CTRL_RST 8'h80
`define UTMIO_ROUTE_RST 28'h0000000
`define UTMIO_TPC_FILE_RST 16'h0000

// external clock multiplier codes
`define UTMIO_MULT_X1 2'h0
`define UTMIO_MULT_X2 2'h1
`define UTMIO_MULT_X4 2'h2

// frame clock period codes
`define UTMIO_PER_10 3'h0
`define UTMIO_PER_20 3'h1
`define UTMIO_PER_40 3'h2
`define UTMIO_PER_80 3'h3
`define UTMIO_PER_2560 3'h4

// output source selections, 4 bits per output
`define UTMIO_SEL_NONE 4'h0
`define UTMIO_SEL_CHIP 4'h1
`define UTMIO_SEL_REPLY 4'h2
`define UTMIO_SEL_FRAME 4'h3
`define UTMIO_SEL_PRACH 4'h4
`define UTMIO_SEL_TPC 4'h5
`define UTMIO_SEL_SFN0 4'h6

// timing
`define UTMIO_PCLK_NS 40
`define UTMIO_PCLK_KHZ 25000
`define UTMIO_CHIP_KHZ 3840
`define UTMIO_CYC_PER_MS (1000000 / `UTMIO_PCLK_NS)
`define UTMIO_FRAME_10_MS 10
`define UTMIO_FRAME_20_MS 20
`define UTMIO_FRAME_40_MS 40
`define UTMIO_FRAME_80_MS 80
`define UTMIO_FRAME_2560_MS 2560
`define UTMIO_PRACH_CHIPS 16'h1000

`endif

// [rtl/utmio_sync.v]
`timescale 1ns/1ps
`default_nettype none
module utmio_sync (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// pin in, filtered level out
	input wire din,
	output reg dout
);
	reg s1;
	reg s2;
	reg s3;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			dout <= 1'b0;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3) begin
				dout <= s3;
			end
		end
	end
endmodule
`default_nettype wire

// [verif/utmio_main_properties.sv]
`timescale 1ns/1ps
`default_nettype none
`include "utmio_defs.vh"
module utmio_chk (
	// clock, reset, apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// routed outputs
	input wire logic event1_out,
	input wire logic event2_out,
	input wire logic event3_out,
	input wire logic event4_out,
	input wire logic data_out,
	input wire logic data_clock_out,
	input wire logic symbol_sync_out
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	wire [6:0] outs = {symbol_sync_out, data_clock_out, data_out, event4_out, event3_out,
		event2_out, event1_out};
	wire setup = psel && !penable;
	wire [6:0] none_now;
	reg [27:0] route;
	reg [6:0] none_q;
	reg [6:0] none_qq;
	genvar i;
	for (i = 0; i < 7; i = i + 1) begin : g_none
		assign none_now[i] = route[4*i+:4] == 4'h0 || route[4*i+:4] > 4'h6;
	end
	// shadow of the routing, delayed to cover output latency
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			route <= 28'h0;
			none_q <= 7'h7F;
			none_qq <= 7'h7F;
		end else begin
			if (psel && penable && pready && pwrite && paddr == `UTMIO_OFF_ROUTE)
				route <= pwdata[27:0];
			none_q <= none_now;
			none_qq <= none_q;
		end
	end
	chk_ready_wait: assert property (setup |=> pready)
		else $error("no pready after setup");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready too long");
	chk_ready_access: assert property (pready |-> psel && penable)
		else $error("pready outside access");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	chk_unmapped_err: assert property (setup && paddr > 12'h00C |=>
		pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped not refused");
	chk_mapped_ok: assert property (setup && paddr <= 12'h00C && paddr[1:0] == 2'h0 |=>
		!pslverr) else $error("mapped access refused");
	chk_reset_quiet: assert property ($rose(presetn) |-> outs == 7'h0)
		else $error("output active after reset");
	chk_none_low: assert property ((outs & none_now & none_q & none_qq) == 7'h0)
		else $error("unassigned output high");
	cover property (pready && pslverr);
	cover property ($rose(event1_out));
	cover property ($rose(event3_out));
endmodule
bind utmio_main utmio_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .event1_out(event1_out), .event2_out(event2_out),
	.event3_out(event3_out), .event4_out(event4_out), .data_out(data_out),
	.data_clock_out(data_clock_out), .symbol_sync_out(symbol_sync_out));
`default_nettype wire

// [verif/utmio_far_end.sv]
`timescale 1ns/1ps
`default_nettype none
module utmio_far_end (
	// clock and reference enable
	input wire logic pclk,
	input wire logic ext_run,
	// pins toward the device
	output logic frame_sync_trigger,
	output logic burst_gate_in,
	output logic tpc_user_trigger,
	output logic external_chip_clock_input
);
	initial begin
		{frame_sync_trigger, burst_gate_in, tpc_user_trigger} = 3'h0;
		external_chip_clock_input = 1'b0;
		#13;
		forever #160 external_chip_clock_input <= ext_run && !external_chip_clock_input;
	end
	// 8 pclk high then 8 low, clear of the pin filter
	task pulse(input int pin);
		@(posedge pclk);
		case (pin)
			0: frame_sync_trigger <= 1'b1;
			1: burst_gate_in <= 1'b1;
			default: tpc_user_trigger <= 1'b1;
		endcase
		repeat (8) @(posedge pclk);
		{frame_sync_trigger, burst_gate_in, tpc_user_trigger} <= 3'h0;
		repeat (8) @(posedge pclk);
	endtask
endmodule
`default_nettype wire

// [verif/utmio_main_test.sv]
`timescale 1ns/1ps
`default_nettype none
`include "utmio_defs.vh"
module utmio_main_test;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic ext_run = 1'b0;
	logic [31:0] rd;
	logic er;
	wire [31:0] prdata;
	wire pready, pslverr, fs, bg, tp, ec;
	wire [6:0] outs;
	int miscompares = 0;
	int total_checks = 0;
	int cycles = 0;
	int n;
	int per[5] = '{100, 200, 400, 800, `UTMIO_FRAME_2560_MS * `UTMIO_CYC_PER_MS};
	always #20 pclk = ~pclk;
	utmio_main #(.FRAME_CYC_10(26'd100), .FRAME_CYC_20(26'd200), .FRAME_CYC_40(26'd400),
		.FRAME_CYC_80(26'd800)) u_dut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.frame_sync_trigger(fs), .burst_gate_in(bg), .tpc_user_trigger(tp),
		.external_chip_clock_input(ec), .event1_out(outs[0]), .event2_out(outs[1]),
		.event3_out(outs[2]), .event4_out(outs[3]), .data_out(outs[4]),
		.data_clock_out(outs[5]), .symbol_sync_out(outs[6]));
	utmio_far_end u_far (.pclk(pclk), .ext_run(ext_run), .frame_sync_trigger(fs),
		.burst_gate_in(bg), .tpc_user_trigger(tp), .external_chip_clock_input(ec));
	task check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task report_and_stop();
		if (miscompares == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 90000) begin
			miscompares++;
			report_and_stop();
		end
	end
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task count(input int idx, input int len);
		logic prev;
		n = 0;
		prev = outs[idx];
		repeat (len) begin
			@(posedge pclk);
			if (outs[idx] && !prev) n++;
			prev = outs[idx];
		end
	endtask
	task wait_hi(input int idx);
		n = 0;
		repeat (60) begin
			@(posedge pclk);
			if (outs[idx] === 1'b1) n = 1;
		end
	endtask
	task fire(input int pin, input int idx);
		fork
			u_far.pulse(pin);
			wait_hi(idx);
		join
	endtask
	task t_defaults();
		apb(0, `UTMIO_OFF_CTRL, 0);
		check(rd, {24'h0, `UTMIO_CTRL_RST});
		apb(0, `UTMIO_OFF_ROUTE, 0);
		check(rd, 32'h0);
		apb(0, 12'h010, 32'hFFFFFFFF);
		check(rd, 32'h0);
		check({31'h0, er}, 32'h1);
	endtask
	task t_reply();
		apb(1, `UTMIO_OFF_ROUTE, {12'h0, `UTMIO_SEL_REPLY, 8'h0, `UTMIO_SEL_CHIP, `UTMIO_SEL_REPLY});
		count(0, 300);
		check(n, 0);
		count(1, 1000);
		check(n >= 150 && n <= 157, 1);
		fire(0, 0);
		check(n, 1);
		fire(0, 4);
		check(n, 1);
	endtask
	task t_prach();
		apb(1, `UTMIO_OFF_ROUTE, {20'h0, `UTMIO_SEL_PRACH, 8'h0});
		apb(1, `UTMIO_OFF_CTRL, 0);
		fire(1, 2);
		check(n, 0);
		apb(1, `UTMIO_OFF_CTRL, 32'h80);
		fire(1, 2);
		check(n, 1);
	endtask
	task t_tpc();
		apb(1, `UTMIO_OFF_TPC_FILE, 32'h1);
		apb(1, `UTMIO_OFF_ROUTE, {16'h0, `UTMIO_SEL_TPC, 12'h0});
		fire(2, 3);
		check(n, 0);
		apb(1, `UTMIO_OFF_CTRL, 0);
		fire(2, 3);
		check(n, 1);
		apb(0, `UTMIO_OFF_STATUS, 0);
		check(rd[10:7], 4'h1);
	endtask
	task t_ext();
		ext_run <= 1'b1;
		apb(1, `UTMIO_OFF_ROUTE, {4'h0, `UTMIO_SEL_CHIP, 20'h0});
		for (int m = 0; m < 3; m++) begin
			apb(1, `UTMIO_OFF_CTRL, {24'h0, 5'h10, m[1:0], 1'b1});
			count(5, 200);
			count(5, 3200);
			check(n >= (400 << m) - 3 && n <= (400 << m) + 3, 1);
		end
		ext_run <= 1'b0;
	endtask
	task t_frame();
		apb(1, `UTMIO_OFF_ROUTE, {`UTMIO_SEL_FRAME, 24'h0});
		for (int p = 0; p < 5; p++) begin
			apb(1, `UTMIO_OFF_CTRL, {24'h0, 1'b1, p[2:0], 4'h0});
			count(6, 4000);
			check(n >= 4000 / per[p] - 1 && n <= 4000 / per[p] + 1, 1);
		end
		apb(0, `UTMIO_OFF_STATUS, 0);
		check(rd[31:20] != 12'h000, 1);
		apb(1, `UTMIO_OFF_ROUTE, {`UTMIO_SEL_SFN0, 24'h0});
		apb(1, `UTMIO_OFF_CTRL, 32'hC8);
		fire(0, 6);
		check(n, 1);
		apb(0, `UTMIO_OFF_STATUS, 0);
		check(rd[31:20], 12'h000);
	endtask
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_defaults();
		t_reply();
		t_prach();
		t_tpc();
		t_ext();
		t_frame();
		report_and_stop();
	end
endmodule
`default_nettype wire
